// ---- hw/mbsra_core.sv ----
// Modbus slave request handler for parameter, process data and time registers
`timescale 1ns/1ns
`default_nettype none
`include "mbsra_params.svh"
module mbsra_core
  import mbsra_pkg::*;
#(
  parameter int PAR_TMO_CYC = `MBSRA_PAR_TMO_CYC,
  parameter int SEC_CYC     = `MBSRA_SEC_CYC
)(
  input  wire logic        clock,
  input  wire logic        rstn,
  input  wire logic [7:0]  own_addr,
  input  wire logic        auto_compat,
  input  wire logic [15:0] mode_param,
  input  wire logic        chk_width,
  input  wire logic        chk_limits,
  input  wire logic        chk_access,
  input  wire logic [15:0] active_fault_code,
  input  wire logic [31:0] fieldbus_output_words [`MBSRA_PD_NUM],
  output logic      [31:0] fieldbus_input_words  [`MBSRA_PD_NUM],
  output logic      [15:0] comm_timeout_setting,
  output logic      [31:0] system_time,
  input  wire logic        req_valid,
  output logic             req_ready,
  input  wire logic [7:0]  req_slave,
  input  wire logic [7:0]  req_func,
  input  wire logic [15:0] req_addr,
  input  wire logic [15:0] req_qty,
  input  wire logic [15:0] req_waddr,
  input  wire logic [15:0] req_wqty,
  input  wire logic [15:0] req_wdata [`MBSRA_BUF_WORDS],
  output logic             rsp_valid,
  input  wire logic        rsp_ready,
  output logic      [7:0]  rsp_func,
  output logic      [7:0]  rsp_exc_code,
  output logic      [3:0]  rsp_words,
  output logic      [15:0] rsp_data [`MBSRA_BUF_WORDS],
  output logic             par_req,
  output logic      [15:0] par_id,
  output logic             par_wide,
  output logic             par_write,
  output logic      [31:0] par_wdata,
  input  wire logic        par_ack,
  input  wire logic        par_exists,
  input  wire logic        par_is32,
  input  wire logic        par_monitor,
  input  wire logic        par_limit_ok,
  input  wire logic [31:0] par_rdata,
  output logic             par_wr_en
);

  // ==========================================
  // Address decoding
  function automatic mbsra_region_e region_of(input logic [15:0] r, input logic compat);
    if (compat && r == `MBSRA_FAULT_REG)
      return RG_FAULT;
    if ((r >= `MBSRA_PAR16_LO && r <= `MBSRA_PAR16_HI) ||
        (r >= `MBSRA_PAR16B_LO && r <= `MBSRA_PAR16B_HI))
      return RG_PAR16;
    if (r >= `MBSRA_PDI16_LO && r <= `MBSRA_PDI16_HI)
      return RG_PDI16;
    if (r >= `MBSRA_PDI32_LO && r <= `MBSRA_PDI32_HI)
      return RG_PDI32;
    if (r >= `MBSRA_PDO16_LO && r <= `MBSRA_PDO16_HI)
      return RG_PDO16;
    if (r >= `MBSRA_PDO32_LO && r <= `MBSRA_PDO32_HI)
      return RG_PDO32;
    if (r == `MBSRA_TIME_HI_REG || r == `MBSRA_TIME_LO_REG)
      return RG_TIME;
    if (r >= `MBSRA_PAR32_LO && r <= `MBSRA_PAR32_HI)
      return RG_PAR32;
    if (r == `MBSRA_TMO_REG)
      return RG_TMO;
    return RG_NONE;
  endfunction

  function automatic logic qty_bad(input logic [15:0] q);
    return (q == `MBSRA_QTY_ZERO) || (q > `MBSRA_MAX_QTY);
  endfunction

  // ==========================================
  // State
  mbsra_state_e st_r;
  logic [7:0]   func_r;
  logic         respond_r;
  logic         wr_phase_r;
  logic [15:0]  cur_r;
  logic [3:0]   rem_r;
  logic [3:0]   idx_r;
  logic [15:0]  rd_addr_r;
  logic [3:0]   rd_qty_r;
  logic         ok_any_r;
  logic [7:0]   exc_r;
  logic [23:0]  wait_r;
  logic [15:0]  wbuf_r [`MBSRA_BUF_WORDS];
  logic [15:0]  rbuf_r [`MBSRA_BUF_WORDS];
  logic [31:0]  pdi_r  [`MBSRA_PD_NUM];
  logic [15:0]  tmo_r;
  logic         par_req_r;
  logic [15:0]  par_id_r;
  logic         par_wide_r;
  logic         par_write_r;
  logic [31:0]  par_wdata_r;

  logic          compat;
  logic          accept;
  mbsra_region_e rg;
  logic          wide;
  logic [3:0]    step_n;
  logic [15:0]   w_a;
  logic [15:0]   w_b;
  logic [15:0]   pd_off;
  logic          pd_ok;
  logic          loc_ok;
  logic [15:0]   loc_a;
  logic [15:0]   loc_b;
  logic          in_item;
  logic          half_err;
  logic          is_par;
  logic          loc_done;
  logic          par_done;
  logic          par_ok;
  logic          step;
  logic          step_ok;
  logic [15:0]   res_a;
  logic [15:0]   res_b;
  logic          wr_commit;
  logic          par_stuck;
  logic          time_load;

  assign compat  = auto_compat || (mode_param == `MBSRA_MODE_COMPAT);
  assign accept  = req_valid && req_ready;
  assign req_ready = (st_r == ST_IDLE);
  assign rg      = region_of(cur_r, compat);
  assign wide    = (rg == RG_PDI32) || (rg == RG_PDO32) || (rg == RG_PAR32) || (rg == RG_TIME);
  assign step_n  = wide ? `MBSRA_STEP32 : `MBSRA_STEP16;
  assign w_a     = wbuf_r[idx_r];
  assign w_b     = wbuf_r[4'(idx_r + `MBSRA_STEP16)];

  // ==========================================
  // Local register item evaluation
  always_comb
  begin
    pd_off = 16'h0000;
    loc_ok = 1'b0;
    loc_a  = 16'h0000;
    loc_b  = 16'h0000;
    case (rg)
      RG_PDI16: pd_off = cur_r - `MBSRA_PDI16_LO;
      RG_PDI32: pd_off = (cur_r - `MBSRA_PDI32_LO) >> 1;
      RG_PDO16: pd_off = cur_r - `MBSRA_PDO16_LO;
      RG_PDO32: pd_off = (cur_r - `MBSRA_PDO32_LO) >> 1;
      default:  pd_off = 16'h0000;
    endcase
    pd_ok = (pd_off < `MBSRA_PD_LIMIT);
    case (rg)
      RG_FAULT:
      begin
        loc_ok = !wr_phase_r;
        loc_a  = active_fault_code;
      end
      RG_PDI16:
      begin
        loc_ok = pd_ok;
        loc_a  = pdi_r[pd_off[3:0]][15:0];
      end
      RG_PDI32:
      begin
        loc_ok = pd_ok;
        loc_a  = pdi_r[pd_off[3:0]][31:16];
        loc_b  = pdi_r[pd_off[3:0]][15:0];
      end
      RG_PDO16:
      begin
        loc_ok = pd_ok && !wr_phase_r;
        loc_a  = fieldbus_output_words[pd_off[3:0]][15:0];
      end
      RG_PDO32:
      begin
        loc_ok = pd_ok && !wr_phase_r;
        loc_a  = fieldbus_output_words[pd_off[3:0]][31:16];
        loc_b  = fieldbus_output_words[pd_off[3:0]][15:0];
      end
      RG_TIME:
      begin
        loc_ok = 1'b1;
        loc_a  = system_time[31:16];
        loc_b  = system_time[15:0];
      end
      RG_TMO:
      begin
        loc_ok = 1'b1;
        loc_a  = tmo_r;
      end
      default:
      begin
        loc_ok = 1'b0;
      end
    endcase
  end

  assign in_item  = (st_r == ST_ITEM) && (rem_r != 4'h0);
  // A 32-bit value must start on its high word and bring its low word along
  assign half_err = in_item && wide && ((rem_r == `MBSRA_STEP16) || !cur_r[0]);
  assign is_par   = (rg == RG_PAR16) || (rg == RG_PAR32);
  assign loc_done = in_item && !half_err && !is_par;
  assign par_done = (st_r == ST_PROBE) && par_ack;
  assign par_ok   = par_exists &&
                    (!wr_phase_r ||
                     ((!chk_width || !wide || par_is32) &&
                      (!chk_limits || par_limit_ok) &&
                      (!chk_access || !par_monitor)));
  assign step     = loc_done || par_done;
  assign step_ok  = par_done ? par_ok : loc_ok;
  assign res_a    = par_done ? (wide ? par_rdata[31:16] : par_rdata[15:0]) : loc_a;
  assign res_b    = par_done ? par_rdata[15:0] : loc_b;
  assign wr_commit = step && step_ok && wr_phase_r;
  assign par_wr_en = par_done && par_ok && wr_phase_r;
  assign par_stuck = (st_r == ST_PROBE) && !par_ack && (wait_r == 24'(PAR_TMO_CYC - 1));
  assign time_load = wr_commit && (rg == RG_TIME);

  // ==========================================
  // Request sequencing
  always_ff @(posedge clock)
  begin
    if (!rstn)
    begin
      st_r       <= ST_IDLE;
      func_r     <= 8'h00;
      respond_r  <= 1'b0;
      wr_phase_r <= 1'b0;
      cur_r      <= 16'h0000;
      rem_r      <= 4'h0;
      idx_r      <= 4'h0;
      rd_addr_r  <= 16'h0000;
      rd_qty_r   <= 4'h0;
      ok_any_r   <= 1'b0;
      exc_r      <= `MBSRA_EXC_NONE;
    end
    else
    begin
      case (st_r)
        ST_IDLE:
        begin
          // Queries for other slaves are taken and dropped; broadcasts run silently
          if (accept && (req_slave == own_addr || req_slave == `MBSRA_BCAST_ADDR))
          begin
            func_r    <= req_func;
            respond_r <= (req_slave == own_addr);
            ok_any_r  <= 1'b0;
            idx_r     <= 4'h0;
            exc_r     <= `MBSRA_EXC_NONE;
            rd_addr_r <= req_addr;
            rd_qty_r  <= req_qty[3:0];
            cur_r     <= req_addr;
            rem_r     <= req_qty[3:0];
            wr_phase_r <= 1'b0;
            st_r      <= ST_ITEM;
            case (req_func)
              `MBSRA_FC_RD_HOLD, `MBSRA_FC_RD_INPUT:
              begin
                if (qty_bad(req_qty))
                begin
                  exc_r <= `MBSRA_EXC_VALUE;
                  st_r  <= ST_RESP;
                end
              end
              `MBSRA_FC_WR_SINGLE:
              begin
                rem_r      <= `MBSRA_STEP16;
                wr_phase_r <= 1'b1;
              end
              `MBSRA_FC_WR_MULTI:
              begin
                wr_phase_r <= 1'b1;
                if (qty_bad(req_qty))
                begin
                  exc_r <= `MBSRA_EXC_VALUE;
                  st_r  <= ST_RESP;
                end
              end
              `MBSRA_FC_RW_MULTI:
              begin
                // Write part runs first, then the read part
                cur_r      <= req_waddr;
                rem_r      <= req_wqty[3:0];
                wr_phase_r <= 1'b1;
                if (qty_bad(req_qty) || qty_bad(req_wqty))
                begin
                  exc_r <= `MBSRA_EXC_VALUE;
                  st_r  <= ST_RESP;
                end
              end
              default:
              begin
                exc_r <= `MBSRA_EXC_FUNC;
                st_r  <= ST_RESP;
              end
            endcase
          end
        end
        ST_ITEM:
        begin
          if (rem_r == 4'h0)
          begin
            if (!ok_any_r)
            begin
              exc_r <= `MBSRA_EXC_ADDR;
              st_r  <= ST_RESP;
            end
            else if (wr_phase_r && func_r == `MBSRA_FC_RW_MULTI)
            begin
              wr_phase_r <= 1'b0;
              cur_r      <= rd_addr_r;
              rem_r      <= rd_qty_r;
              idx_r      <= 4'h0;
              ok_any_r   <= 1'b0;
            end
            else
              st_r <= ST_RESP;
          end
          else if (half_err)
          begin
            exc_r <= `MBSRA_EXC_ADDR;
            st_r  <= ST_RESP;
          end
          else if (is_par)
            st_r <= ST_PROBE;
        end
        ST_PROBE:
        begin
          if (par_stuck)
          begin
            exc_r <= `MBSRA_EXC_FAIL;
            st_r  <= ST_RESP;
          end
          else if (par_ack)
            st_r <= ST_ITEM;
        end
        ST_RESP:
        begin
          if (!respond_r || rsp_ready)
            st_r <= ST_IDLE;
        end
        default:
          st_r <= ST_IDLE;
      endcase
      if (step)
      begin
        if (step_ok || compat)
        begin
          // Legacy mode keeps going past a failed ID
          ok_any_r <= ok_any_r || step_ok;
          cur_r    <= cur_r + {12'h000, step_n};
          rem_r    <= rem_r - step_n;
          idx_r    <= idx_r + step_n;
        end
        else
        begin
          exc_r <= `MBSRA_EXC_ADDR;
          st_r  <= ST_RESP;
        end
      end
    end
  end

  // ==========================================
  // Data buffers
  always_ff @(posedge clock)
  begin
    if (!rstn)
    begin
      for (int i = 0; i < `MBSRA_BUF_WORDS; i++)
        wbuf_r[i] <= 16'h0000;
    end
    else if (accept)
      wbuf_r <= req_wdata;
  end

  always_ff @(posedge clock)
  begin
    if (!rstn)
    begin
      for (int i = 0; i < `MBSRA_BUF_WORDS; i++)
        rbuf_r[i] <= 16'h0000;
    end
    else if (step && !wr_phase_r)
    begin
      rbuf_r[idx_r] <= step_ok ? res_a : 16'h0000;
      if (wide)
        rbuf_r[4'(idx_r + `MBSRA_STEP16)] <= step_ok ? res_b : 16'h0000;
    end
  end

  // ==========================================
  // Locally held registers
  generate
    for (genvar g = 0; g < `MBSRA_PD_NUM; g++)
    begin : g_pdi
      always_ff @(posedge clock)
      begin
        if (!rstn)
          pdi_r[g] <= 32'h0000_0000;
        else if (wr_commit && pd_off[3:0] == 4'(g) && rg == RG_PDI16)
          pdi_r[g] <= {pdi_r[g][31:16], w_a};
        else if (wr_commit && pd_off[3:0] == 4'(g) && rg == RG_PDI32)
          pdi_r[g] <= {w_a, w_b};
      end
      assign fieldbus_input_words[g] = pdi_r[g];
    end
  endgenerate

  always_ff @(posedge clock)
  begin
    if (!rstn)
      tmo_r <= 16'h0000;
    else if (wr_commit && rg == RG_TMO)
      tmo_r <= w_a;
  end

  assign comm_timeout_setting = tmo_r;

  mbsra_seconds #(
    .SEC_CYC (SEC_CYC)
  ) u_seconds (
    .clock      (clock),
    .rstn       (rstn),
    .load       (time_load),
    .load_value ({w_a, w_b}),
    .seconds    (system_time)
  );

  // ==========================================
  // Drive parameter access
  always_ff @(posedge clock)
  begin
    if (!rstn)
    begin
      par_req_r   <= 1'b0;
      par_id_r    <= 16'h0000;
      par_wide_r  <= 1'b0;
      par_write_r <= 1'b0;
      par_wdata_r <= 32'h0000_0000;
      wait_r      <= 24'h00_0000;
    end
    else if (in_item && !half_err && is_par)
    begin
      par_req_r   <= 1'b1;
      par_id_r    <= wide ? ((cur_r - `MBSRA_PAR32_BASE + `MBSRA_ONE16) >> 1) : cur_r;
      par_wide_r  <= wide;
      par_write_r <= wr_phase_r;
      par_wdata_r <= wide ? {w_a, w_b} : {16'h0000, w_a};
      wait_r      <= 24'h00_0000;
    end
    else if (par_ack || par_stuck)
      par_req_r <= 1'b0;
    else if (par_req_r)
      wait_r <= wait_r + 24'h00_0001;
  end

  assign par_req   = par_req_r;
  assign par_id    = par_id_r;
  assign par_wide  = par_wide_r;
  assign par_write = par_write_r;
  assign par_wdata = par_wdata_r;

  // ==========================================
  // Response
  assign rsp_valid    = (st_r == ST_RESP) && respond_r;
  assign rsp_func     = (exc_r != `MBSRA_EXC_NONE) ? (func_r | `MBSRA_EXC_FLAG) : func_r;
  assign rsp_exc_code = exc_r;
  assign rsp_words    = (exc_r == `MBSRA_EXC_NONE && !(func_r == `MBSRA_FC_WR_SINGLE ||
                         func_r == `MBSRA_FC_WR_MULTI)) ? rd_qty_r : 4'h0;
  assign rsp_data     = rbuf_r;

endmodule
`default_nettype wire

// ---- hw/mbsra_params.svh ----
// Constants of the Modbus slave register access block
`ifndef MBSRA_PARAMS_SVH
`define MBSRA_PARAMS_SVH

// ==========================================
// Function and exception codes
`define MBSRA_FC_RD_HOLD   8'h03
`define MBSRA_FC_RD_INPUT  8'h04
`define MBSRA_FC_WR_SINGLE 8'h06
`define MBSRA_FC_WR_MULTI  8'h10
`define MBSRA_FC_RW_MULTI  8'h17
`define MBSRA_EXC_NONE     8'h00
`define MBSRA_EXC_FUNC     8'h01
`define MBSRA_EXC_ADDR     8'h02
`define MBSRA_EXC_VALUE    8'h03
`define MBSRA_EXC_FAIL     8'h04
`define MBSRA_EXC_BUSY     8'h06
`define MBSRA_EXC_PARITY   8'h08
`define MBSRA_EXC_FLAG     8'h80
`define MBSRA_BCAST_ADDR   8'h00
`define MBSRA_MODE_COMPAT  16'h0002

// ==========================================
// Sizes
`define MBSRA_MAX_QTY      16'h000c
`define MBSRA_QTY_ZERO     16'h0000
`define MBSRA_BUF_WORDS    12
`define MBSRA_PD_NUM       16
`define MBSRA_PD_LIMIT     16'h0010
`define MBSRA_STEP16       4'h1
`define MBSRA_STEP32       4'h2

// ==========================================
// Register map
`define MBSRA_PAR16_LO     16'h0001
`define MBSRA_PAR16_HI     16'h07d0
`define MBSRA_PAR16B_LO    16'h0898
`define MBSRA_PAR16B_HI    16'h2710
`define MBSRA_FAULT_REG    16'h0062
`define MBSRA_PDI16_LO     16'h07d1
`define MBSRA_PDI16_HI     16'h0802
`define MBSRA_PDI32_LO     16'h0803
`define MBSRA_PDI32_HI     16'h0833
`define MBSRA_PDO16_LO     16'h0835
`define MBSRA_PDO16_HI     16'h0866
`define MBSRA_PDO32_LO     16'h0867
`define MBSRA_PDO32_HI     16'h0897
`define MBSRA_PAR32_BASE   16'h4e20
`define MBSRA_PAR32_LO     16'h4e21
`define MBSRA_PAR32_HI     16'h9c40
`define MBSRA_TIME_HI_REG  16'h620d
`define MBSRA_TIME_LO_REG  16'h620e
`define MBSRA_TMO_REG      16'h9e35
`define MBSRA_ONE16        16'h0001

// ==========================================
// Timing
`define MBSRA_CLK_HZ       10000000
`define MBSRA_PAR_TMO_US   1000
`define MBSRA_PAR_TMO_CYC  ((`MBSRA_CLK_HZ / 1000000) * `MBSRA_PAR_TMO_US)
`define MBSRA_SEC_S        1
`define MBSRA_SEC_CYC      (`MBSRA_CLK_HZ * `MBSRA_SEC_S)

`endif

// ---- hw/mbsra_pkg.sv ----
// Types of the Modbus slave register access block
package mbsra_pkg;

  typedef logic [15:0] mbsra_word_t;

  typedef enum logic [3:0] {
    RG_NONE, RG_PAR16, RG_FAULT, RG_PDI16, RG_PDI32,
    RG_PDO16, RG_PDO32, RG_PAR32, RG_TIME, RG_TMO
  } mbsra_region_e;

  typedef enum logic [1:0] {
    ST_IDLE, ST_ITEM, ST_PROBE, ST_RESP
  } mbsra_state_e;

endpackage

// ---- hw/mbsra_seconds.sv ----
// Drive system time seconds counter, halted until first set
`timescale 1ns/1ns
`default_nettype none
`include "mbsra_params.svh"
module mbsra_seconds
  import mbsra_pkg::*;
#(
  parameter int SEC_CYC = `MBSRA_SEC_CYC
)(
  input  wire logic        clock,
  input  wire logic        rstn,
  input  wire logic        load,
  input  wire logic [31:0] load_value,
  output logic      [31:0] seconds
);

  logic        run_r;
  logic [31:0] pre_r;
  logic [31:0] sec_r;
  logic        tick;

  assign tick    = run_r && (pre_r == 32'(SEC_CYC - 1));
  assign seconds = sec_r;

  // Without a stored time the count would be meaningless, so it waits for a set
  always_ff @(posedge clock)
  begin
    if (!rstn)
      run_r <= 1'b0;
    else if (load)
      run_r <= 1'b1;
  end

  always_ff @(posedge clock)
  begin
    if (!rstn || load || tick)
      pre_r <= 32'h0000_0000;
    else if (run_r)
      pre_r <= pre_r + 32'h0000_0001;
  end

  always_ff @(posedge clock)
  begin
    if (!rstn)
      sec_r <= 32'h0000_0000;
    else if (load)
      sec_r <= load_value;
    else if (tick)
      sec_r <= sec_r + 32'h0000_0001;
  end

endmodule
`default_nettype wire

// ---- verif/mbsra_checker.sv ----
// Port assertions for the Modbus slave request handler
`timescale 1ns/1ns
`default_nettype none
module mbsra_checker (
  input wire logic        clock,
  input wire logic        rstn,
  input wire logic [7:0]  own_addr,
  input wire logic        chk_width,
  input wire logic        chk_limits,
  input wire logic        chk_access,
  input wire logic        req_valid,
  input wire logic        req_ready,
  input wire logic [7:0]  req_slave,
  input wire logic [7:0]  req_func,
  input wire logic [15:0] req_qty,
  input wire logic        rsp_valid,
  input wire logic [7:0]  rsp_func,
  input wire logic [7:0]  rsp_exc_code,
  input wire logic        par_wide,
  input wire logic        par_ack,
  input wire logic        par_exists,
  input wire logic        par_is32,
  input wire logic        par_monitor,
  input wire logic        par_limit_ok,
  input wire logic        par_wr_en
);
  logic take_own;
  assign take_own = req_valid && req_ready && req_slave == own_addr;
  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);
  // ==========================================
  // Decode refusals
  property p_bad_func;
    take_own && req_func == 8'h05 |-> ##1 rsp_valid && rsp_exc_code == 8'h01;
  endproperty
  a_bad_func: assert property (p_bad_func) else $error("bad code not refused");
  property p_qty;
    take_own && req_func == 8'h03 && (req_qty == 16'h0000 || req_qty > 16'h000c)
      |-> ##1 rsp_valid && rsp_exc_code == 8'h03;
  endproperty
  a_qty: assert property (p_qty) else $error("bad quantity not refused");
  property p_exc_echo;
    rsp_valid && rsp_exc_code != 8'h00 |-> rsp_func[7];
  endproperty
  a_exc_echo: assert property (p_exc_echo) else $error("exception flag missing");
  // Broadcasts here are short, so eight quiet cycles cover them
  property p_bcast;
    req_valid && req_ready && req_slave == 8'h00 |-> !rsp_valid [*8];
  endproperty
  a_bcast: assert property (p_bcast) else $error("broadcast answered");
  // ==========================================
  // Write commit
  property p_exists;
    par_wr_en |-> par_ack && par_exists;
  endproperty
  a_exists: assert property (p_exists) else $error("commit to absent id");
  property p_limit;
    par_wr_en && chk_limits |-> par_limit_ok;
  endproperty
  a_limit: assert property (p_limit) else $error("commit out of limits");
  property p_monitor;
    par_wr_en && chk_access |-> !par_monitor;
  endproperty
  a_monitor: assert property (p_monitor) else $error("commit to monitor");
  property p_width;
    par_wr_en && chk_width && par_wide |-> par_is32;
  endproperty
  a_width: assert property (p_width) else $error("wide commit to narrow id");
endmodule
bind mbsra_core mbsra_checker mbsra_checker_i (.*);
`default_nettype wire

// ---- verif/mbsra_drive_model.sv ----
// Behavioural drive parameter store answering the handler's probes
`timescale 1ns/1ns
`default_nettype none
module mbsra_drive_model (
  input  wire logic        clock,
  input  wire logic        rstn,
  input  wire logic [7:0]  lat,
  input  wire logic        par_req,
  input  wire logic [15:0] par_id,
  input  wire logic [31:0] par_wdata,
  input  wire logic        par_write,
  input  wire logic        par_wr_en,
  output logic             par_ack,
  output logic             par_exists,
  output logic             par_is32,
  output logic             par_monitor,
  output logic             par_limit_ok,
  output logic      [31:0] par_rdata
);
  logic [31:0] store_r [16];
  logic [7:0]  wait_r;
  // ==========================================
  // Id 7 is absent, 9 a monitor value, 5 the only 32-bit one
  assign par_exists   = par_id != 16'h0007;
  assign par_monitor  = par_id == 16'h0009;
  assign par_is32     = par_id == 16'h0005;
  assign par_limit_ok = par_wdata < 32'h0000_8000;
  // Complement between answers so a stale word never passes as fresh
  assign par_rdata = par_ack ? store_r[par_id[3:0]] : ~store_r[par_id[3:0]];
  always_ff @(posedge clock)
  begin
    par_ack <= 1'b0;
    wait_r  <= 8'h00;
    if (rstn && par_req && !par_ack)
    begin
      wait_r  <= wait_r + 8'h01;
      par_ack <= wait_r == lat;
    end
  end
  always_ff @(posedge clock)
  begin
    if (!rstn)
      for (int i = 0; i < 16; i++)
        store_r[i] <= 32'h0001_0001 * 32'(i);
    else if (par_wr_en && par_write)
      store_r[par_id[3:0]] <= par_wdata;
  end
endmodule
`default_nettype wire

// ---- verif/tb.sv ----
// Self-checking bench for the Modbus slave request handler
`timescale 1ns/1ns
`default_nettype none
module tb;
  logic        clock, req_ready, rsp_valid, par_req, par_wide, par_write, par_wr_en;
  logic        par_ack, par_exists, par_is32, par_monitor, par_limit_ok;
  logic        rstn = 1'b0, auto_compat = 1'b0, req_valid = 1'b0, rsp_ready = 1'b0;
  logic        chk_width = 1'b1, chk_limits = 1'b1, chk_access = 1'b1;
  logic [7:0]  own_addr = 8'h05, req_slave = 8'h05, req_func = 8'h00, lat = 8'h00;
  logic [7:0]  rsp_func, rsp_exc_code;
  logic [3:0]  rsp_words;
  logic [15:0] mode_param = 16'h0000, active_fault_code = 16'h0123;
  logic [15:0] req_addr = 16'h0000, req_qty = 16'h0000;
  logic [15:0] req_waddr, req_wqty, comm_timeout_setting, par_id;
  logic [15:0] req_wdata [12] = '{default: 16'h0000};
  logic [15:0] rsp_data [12];
  logic [31:0] fieldbus_output_words [16];
  logic [31:0] fieldbus_input_words [16];
  logic [31:0] system_time, par_rdata, par_wdata, t0;
  int          mismatches, checks_done;
  assign req_waddr = req_addr;
  assign req_wqty  = req_qty;
  mbsra_core #(.PAR_TMO_CYC(20), .SEC_CYC(10)) mbsra_core_i (.*);
  mbsra_drive_model mbsra_drive_model_i (.*);
  initial
  begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  // ==========================================
  // Shared tasks
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    checks_done++;
    if (seen !== want)
    begin
      mismatches++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, want);
    end
  endtask
  task automatic conclude;
    if (mismatches == 0 && checks_done > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // Write words ride in d0/d1; for reads they are the expected words
  task automatic xfer(input logic [7:0] fc, input logic [15:0] adr, input logic [3:0] qty,
                      input logic [3:0] exc, input logic [15:0] d0 = 16'h0000, d1 = 16'h0000);
    int n;
    req_func     = fc;
    req_addr     = adr;
    req_qty      = {12'h000, qty};
    req_wdata[0] = d0;
    req_wdata[1] = d1;
    req_valid    = 1'b1;
    @(negedge clock);
    req_valid = 1'b0;
    for (n = 0; n < 100 && rsp_valid !== 1'b1; n++)
      @(negedge clock);
    if (req_slave != own_addr)
      check(rsp_valid, 1'b0);
    else if (n == 100)
    begin
      mismatches++;
      conclude();
    end
    else
    begin
      check(rsp_exc_code, exc);
      check(rsp_func, exc != 4'h0 ? fc | 8'h80 : fc);
      check(rsp_words, (exc == 4'h0 && fc != 8'h06 && fc != 8'h10) ? qty : 4'h0);
      if (exc == 4'h0 && fc != 8'h06 && fc != 8'h10)
        check(rsp_data[0], d0);
      if (exc == 4'h0 && fc != 8'h06 && fc != 8'h10 && qty > 4'h1)
        check(rsp_data[1], d1);
      rsp_ready = 1'b1;
      @(negedge clock);
      rsp_ready = 1'b0;
    end
  endtask
  // ==========================================
  // Scenarios
  task automatic s_basic;
    xfer(8'h03, 16'h0835, 4'h1, 4'h0, 16'h2000);
    xfer(8'h04, 16'h0836, 4'h1, 4'h0, 16'h2001);
    xfer(8'h03, 16'h0867, 4'h2, 4'h0, 16'h1000, 16'h2000);
    xfer(8'h05, 16'h0003, 4'h1, 4'h1);
    xfer(8'h06, 16'h0835, 4'h1, 4'h2, 16'h0001);
    xfer(8'h03, 16'h07d1, 4'hd, 4'h3);
    xfer(8'h03, 16'h07d1, 4'hc, 4'h0);
  endtask
  task automatic s_param;
    lat = 8'h03;
    xfer(8'h06, 16'h0003, 4'h1, 4'h0, 16'h0042);
    xfer(8'h03, 16'h0003, 4'h1, 4'h0, 16'h0042);
    xfer(8'h17, 16'h0003, 4'h1, 4'h0, 16'h0042);
    xfer(8'h03, 16'h0898, 4'h1, 4'h0, 16'h0008);
    xfer(8'h03, 16'h0007, 4'h1, 4'h2);
    xfer(8'h06, 16'h0009, 4'h1, 4'h2, 16'h0001);
    xfer(8'h06, 16'h0003, 4'h1, 4'h2, 16'h8000);
    {chk_limits, chk_access} = 2'b00;
    xfer(8'h06, 16'h0003, 4'h1, 4'h0, 16'h8000);
    xfer(8'h06, 16'h0009, 4'h1, 4'h0, 16'h0001);
    {chk_limits, chk_access} = 2'b11;
    xfer(8'h03, 16'h0006, 4'h2, 4'h2);
    xfer(8'h03, 16'h9e35, 4'h1, 4'h0);
    xfer(8'h06, 16'h9e35, 4'h1, 4'h0, 16'h0007);
    check(comm_timeout_setting, 16'h0007);
    lat = 8'h28;
    xfer(8'h03, 16'h0003, 4'h1, 4'h4);
    lat = 8'h00;
  endtask
  task automatic s_wide;
    xfer(8'h03, 16'h4e29, 4'h2, 4'h0, 16'h0005, 16'h0005);
    xfer(8'h03, 16'h4e2a, 4'h1, 4'h2);
    xfer(8'h10, 16'h4e29, 4'h1, 4'h2);
    xfer(8'h10, 16'h4e25, 4'h2, 4'h2, 16'h0000, 16'h0001);
    xfer(8'h10, 16'h4e29, 4'h2, 4'h0, 16'h0000, 16'h0077);
    xfer(8'h03, 16'h4e29, 4'h2, 4'h0, 16'h0000, 16'h0077);
  endtask
  task automatic s_legacy;
    mode_param = 16'h0002;
    xfer(8'h03, 16'h0062, 4'h1, 4'h0, 16'h0123);
    xfer(8'h03, 16'h0006, 4'h2, 4'h0, 16'h0006, 16'h0000);
    xfer(8'h03, 16'h0007, 4'h1, 4'h2);
    xfer(8'h10, 16'h0006, 4'h2, 4'h0, 16'h0021, 16'h0022);
    xfer(8'h03, 16'h0006, 4'h1, 4'h0, 16'h0021);
    mode_param  = 16'h0000;
    auto_compat = 1'b1;
    xfer(8'h04, 16'h0062, 4'h1, 4'h0, 16'h0123);
    auto_compat = 1'b0;
    xfer(8'h03, 16'h0062, 4'h1, 4'h0, 16'h0002);
  endtask
  task automatic s_time;
    repeat (30) @(negedge clock);
    check(system_time, 32'h0000_0000);
    xfer(8'h03, 16'h620d, 4'h2, 4'h0);
    xfer(8'h10, 16'h620d, 4'h2, 4'h0, 16'h5b92, 16'h51e1);
    t0 = system_time;
    check(t0, 32'h5b92_51e1);
    repeat (10) @(negedge clock);
    check(system_time, t0 + 32'h0000_0001);
  endtask
  task automatic s_bcast;
    xfer(8'h10, 16'h0803, 4'h2, 4'h0, 16'hcafe, 16'hf00d);
    check(fieldbus_input_words[0], 32'hcafe_f00d);
    req_slave = 8'h00;
    xfer(8'h06, 16'h07d1, 4'h1, 4'h0, 16'h1234);
    check(fieldbus_input_words[0], 32'hcafe_1234);
    req_slave = 8'h09;
    xfer(8'h03, 16'h0003, 4'h1, 4'h0);
    req_slave = 8'h05;
  endtask
  initial
  begin
    for (int i = 0; i < 16; i++)
      fieldbus_output_words[i] = {16'h1000 + 16'(i), 16'h2000 + 16'(i)};
    repeat (5) @(negedge clock);
    rstn = 1'b1;
    s_basic();
    s_param();
    s_wide();
    s_legacy();
    s_time();
    s_bcast();
    conclude();
  end
endmodule
`default_nettype wire
